// ===== src/ldk_params.svh
// constants for the led display and key scan controller
`ifndef LDK_PARAMS_SVH
`define LDK_PARAMS_SVH

`define LDK_RAM_DEPTH      14
`define LDK_ADDR_LAST      4'h0_00D
`define LDK_ADDR_RESET     4'h0
`define LDK_KEY_LINES      10
`define LDK_KEY_RETURNS    3
`define LDK_KEY_BITS       30
`define LDK_READ_BITS      6'h0_028
`define LDK_BYTE_KEYS      3'h6
`define LDK_MODE7_RESET    1'b1
`define LDK_DSET_RESET     4'h0
`define LDK_PW_RESET       3'h0
`define LDK_STEPS_LAST     4'hF
`define LDK_KEY_STEP_LAST  4'h4
`define LDK_SUB_CYCLES     64
`define LDK_GRIDS_MODE7    3'h7
`define LDK_GRIDS_MODE6    3'h6

// command byte fields
`define LDK_CMD_MODE       2'h0
`define LDK_CMD_DATA       2'h1
`define LDK_CMD_CTRL       2'h2
`define LDK_CMD_ADDR       2'h3
`define LDK_DSET_READ_BIT  1
`define LDK_DSET_FIXED_BIT 2
`define LDK_CTRL_ON_BIT    3

`endif

// ===== src/ldk_pkg.sv
// types for the led display and key scan controller
package ldk_pkg;

    typedef enum logic [1:0] {
        LS_CMD,
        LS_WRITE,
        LS_READ
    } ldk_link_state_t;

    // link side state, clocked by the host shift clock
    typedef struct packed {
        ldk_link_state_t lst;
        logic [7:0]      sh;
        logic [2:0]      cnt;
        logic [7:0]      byte_r;
        logic            is_cmd;
        logic            tgl;
        logic [5:0]      rd_ptr;
    } ldk_link_t;

    // core side state, clocked by the internal timing clock
    typedef struct packed {
        logic        tgl_s1;
        logic        tgl_s2;
        logic        tgl_s3;
        logic [2:0]  key_s1;
        logic [2:0]  key_s2;
        logic        mode7;
        logic [3:0]  dset;
        logic [3:0]  addr;
        logic        disp_on;
        logic [2:0]  pw;
        logic [7:0]  sub_cnt;
        logic [3:0]  step;
        logic [2:0]  slot;
        logic        frame_odd;
        logic [29:0] key_tmp;
        logic [29:0] key_store;
        logic [29:0] key_tx;
        logic [9:0]  seg;
        logic        seg11;
        logic        shared;
        logic [5:0]  grid;
    } ldk_core_t;

endpackage

// ===== src/ldk_ctrl.sv
// led display and key scan controller driven by a strobed serial link
// Operation
// - sample serial input on shift clock rise, drive read bits on fall
// - data pin is input on writes, open-drain pull-low output on reads
// - strobe high makes the link ignore all shift clock edges
// - first byte after strobe falls is the command byte, b0 first
// - strobe rising mid-byte resets the receiver and drops the partial byte
// - key returns are latched into key storage only at display cycle end
// - command with top bits 00 is display mode, bits b2 to b5 ignored
// - mode selects 12 segments by 6 grids or 11 segments by 7 grids
// - display stays off after a mode change until display-on command
// - selecting the already active mode does nothing
// - power-up mode is 7 grids, 11 segments
// - command with top bits 01 is data setting, bits b4 b5 ignored
// - power-up data setting field is zero
// - scan a 10 by 3 key matrix, store it, return it on read
// - key bytes shift out lowest bit first, back to back
// - top two bits of each key byte carry no key data
// - address command loads pointer, valid addresses 00h to 0dh
// - pointer at 0eh or above discards display data bytes
// - power-up address pointer is zero
// - byte wide display ram, two addresses per digit, seven digits
// - display control switches display and picks pulse width
// - power-up width 1/16, display off, key scan running
// - auto addressing increments the pointer after each stored byte
// - one key scan cycle spans two display frames
`timescale 1ns/1ps
`include "ldk_params.svh"

module ldk_ctrl #(
    parameter int SUB_CYCLES = `LDK_SUB_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        shift_clock,
    input  wire logic        frame_select_strobe,
    input  wire logic        shared_serial_data_pin_in,
    output logic             shared_serial_data_pin_out,
    output logic             shared_serial_data_pin_oe,
    input  wire logic [2:0]  key_return_inputs,
    output logic      [9:0]  segment_keysource_outputs,
    output logic             segment_eleven_output,
    output logic             shared_segment_grid_output,
    output logic      [5:0]  grid_drive_outputs,
    output logic             display_enabled,
    output logic             seven_grid_mode,
    output logic      [2:0]  pulse_width_code,
    output logic      [3:0]  address_pointer
);

    ldk_pkg::ldk_link_t link_r;
    ldk_pkg::ldk_link_t link_nxt;
    ldk_pkg::ldk_core_t core_r;
    ldk_pkg::ldk_core_t core_nxt;
    logic               pull_low_r;
    logic               link_rst_b;
    logic [7:0]         ram [`LDK_RAM_DEPTH];
    logic               ram_we;
    logic [3:0]         ram_wa;
    logic [7:0]         ram_wd;
    // byte handoff toward the core; cleared by rst_b only, never by the strobe
    logic               hand_tgl_r;
    logic               hand_cmd_r;
    logic [7:0]         hand_byte_r;

    // key bit at a read position; bits 6, 7 and bits past the end leave the pin released
    function automatic logic key_bit(input logic [29:0] keys, input logic [5:0] ptr);
        logic [5:0] idx;
        // widen before the product so byte 2 and above do not wrap in three bits
        idx = 6'({3'h0, ptr[5:3]} * {3'h0, `LDK_BYTE_KEYS}) + {3'h0, ptr[2:0]};
        if (ptr[2:0] >= `LDK_BYTE_KEYS || ptr >= `LDK_READ_BITS) begin
            key_bit = 1'b1;
        end else begin
            key_bit = keys[idx[4:0]];
        end
    endfunction

    // strobe high holds the whole link side in reset, so a partial byte is lost
    assign link_rst_b = rst_b & ~frame_select_strobe;

    // link side: shift in lsb first on the rising edge, frame the bytes
    always_comb begin
        link_nxt = link_r;
        case (link_r.lst)
            ldk_pkg::LS_CMD, ldk_pkg::LS_WRITE: begin
                link_nxt.sh  = {shared_serial_data_pin_in, link_r.sh[7:1]};
                link_nxt.cnt = link_r.cnt + 3'h1;
                if (link_r.cnt == 3'h7) begin
                    link_nxt.byte_r = link_nxt.sh;
                    link_nxt.is_cmd = (link_r.lst == ldk_pkg::LS_CMD);
                    link_nxt.tgl    = ~link_r.tgl;
                    if (link_r.lst == ldk_pkg::LS_CMD && link_nxt.sh[7:6] == `LDK_CMD_DATA
                        && link_nxt.sh[`LDK_DSET_READ_BIT]) begin
                        link_nxt.lst    = ldk_pkg::LS_READ;
                        link_nxt.rd_ptr = 6'h0;
                    end else begin
                        link_nxt.lst = ldk_pkg::LS_WRITE;
                    end
                end
            end
            ldk_pkg::LS_READ: begin
                // each rising edge moves on to the next bit, crossing bytes freely
                if (link_r.rd_ptr < `LDK_READ_BITS) begin
                    link_nxt.rd_ptr = link_r.rd_ptr + 6'h1;
                end
            end
            default: begin
                link_nxt.lst = ldk_pkg::LS_CMD;
            end
        endcase
    end

    // link side registers
    always_ff @(posedge shift_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            link_r <= '0;
        end else begin
            link_r <= link_nxt;
        end
    end

    // handoff flops: a strobe rise resets the link side but must not look like a new byte
    always_ff @(posedge shift_clock or negedge rst_b) begin
        if (!rst_b) begin
            hand_tgl_r  <= 1'b0;
            hand_cmd_r  <= 1'b0;
            hand_byte_r <= 8'h00;
        end else if (link_nxt.tgl != link_r.tgl) begin
            hand_tgl_r  <= ~hand_tgl_r;
            hand_cmd_r  <= link_nxt.is_cmd;
            hand_byte_r <= link_nxt.byte_r;
        end
    end

    // read bits leave on the falling edge; pin is only ever pulled low
    always_ff @(negedge shift_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            pull_low_r <= 1'b0;
        end else begin
            pull_low_r <= (link_r.lst == ldk_pkg::LS_READ)
                          && !key_bit(core_r.key_tx, link_r.rd_ptr);
        end
    end

    assign shared_serial_data_pin_out = 1'b0;
    assign shared_serial_data_pin_oe  = pull_low_r;

    // core side: commands, data bytes, multiplexing and key scan
    always_comb begin
        logic       ev;
        logic [7:0] b;
        logic [2:0] ngrid;
        logic       sub_end;
        logic [3:0] line;
        logic [3:0] da;
        logic       lit;
        logic [6:0] gsel;
        logic [11:0] pat;
        ev       = 1'b0;
        b        = 8'h0;
        ngrid    = 3'h0;
        sub_end  = 1'b0;
        line     = 4'h0;
        da       = 4'h0;
        lit      = 1'b0;
        gsel     = 7'h0;
        pat      = 12'h0;
        core_nxt = core_r;
        ram_we   = 1'b0;
        ram_wa   = core_r.addr;
        ram_wd   = 8'h0;

        // toggle and key pins pass two flops before use
        core_nxt.tgl_s1 = hand_tgl_r;
        core_nxt.tgl_s2 = core_r.tgl_s1;
        core_nxt.tgl_s3 = core_r.tgl_s2;
        core_nxt.key_s1 = key_return_inputs;
        core_nxt.key_s2 = core_r.key_s1;
        // the byte stays put until the next eight shift clocks, so it is safe here
        ev = core_r.tgl_s2 ^ core_r.tgl_s3;
        b  = hand_byte_r;

        if (ev && hand_cmd_r) begin
            case (b[7:6])
                `LDK_CMD_MODE: begin
                    // only b0 picks the mode; b2 to b5 play no part
                    if (b[0] != core_r.mode7) begin
                        core_nxt.mode7   = b[0];
                        core_nxt.disp_on = 1'b0;
                    end
                end
                `LDK_CMD_DATA: begin
                    core_nxt.dset = b[3:0];
                    if (b[`LDK_DSET_READ_BIT]) begin
                        // snapshot for the link; the host wait covers this crossing
                        core_nxt.key_tx = core_r.key_store;
                    end
                end
                `LDK_CMD_CTRL: begin
                    core_nxt.disp_on = b[`LDK_CTRL_ON_BIT];
                    core_nxt.pw      = b[2:0];
                end
                `LDK_CMD_ADDR: begin
                    core_nxt.addr = b[3:0];
                end
                default: begin
                    core_nxt.addr = core_r.addr;
                end
            endcase
        end else if (ev && !core_r.dset[`LDK_DSET_READ_BIT]) begin
            // data byte: store only while the pointer is valid
            if (core_r.addr <= `LDK_ADDR_LAST) begin
                ram_we = 1'b1;
                ram_wd = b;
                if (!core_r.dset[`LDK_DSET_FIXED_BIT]) begin
                    core_nxt.addr = core_r.addr + 4'h1;
                end
            end
        end

        // multiplex timing runs on clk alone, never on the shift clock
        ngrid   = core_r.mode7 ? `LDK_GRIDS_MODE7 : `LDK_GRIDS_MODE6;
        sub_end = (core_r.sub_cnt == 8'(SUB_CYCLES - 1));
        core_nxt.sub_cnt = sub_end ? 8'h0 : core_r.sub_cnt + 8'h1;
        line = (core_r.frame_odd ? 4'h5 : 4'h0) + core_r.step;

        if (core_r.slot == ngrid) begin
            // key slot: one source line per step, half of the lines per frame
            core_nxt.seg    = 10'h0;
            core_nxt.seg[line] = 1'b1;
            core_nxt.seg11  = 1'b0;
            core_nxt.shared = 1'b0;
            core_nxt.grid   = 6'h0;
            if (sub_end) begin
                core_nxt.key_tmp[6'(line) * 3 +: 3] = core_r.key_s2;
                core_nxt.step = core_r.step + 4'h1;
                if (core_r.step == `LDK_KEY_STEP_LAST) begin
                    core_nxt.step      = 4'h0;
                    core_nxt.slot      = 3'h0;
                    core_nxt.frame_odd = ~core_r.frame_odd;
                    if (core_r.frame_odd) begin
                        core_nxt.key_store = core_nxt.key_tmp;
                    end
                end
            end
        end else begin
            // grid slot: digit pattern from two ram bytes, dimmed by pulse width
            da   = {core_r.slot, 1'b0};
            pat  = {ram[da + 4'h1][3:0], ram[da]};
            lit  = core_r.disp_on && (core_r.step <= {1'b0, core_r.pw});
            gsel = 7'h0;
            gsel[core_r.slot] = lit;
            core_nxt.seg    = lit ? pat[9:0] : 10'h0;
            core_nxt.seg11  = lit & pat[10];
            core_nxt.grid   = gsel[5:0];
            // shared pin is the seventh grid or the twelfth segment
            core_nxt.shared = core_r.mode7 ? gsel[6] : (lit & pat[11]);
            if (sub_end) begin
                core_nxt.step = core_r.step + 4'h1;
                if (core_r.step == `LDK_STEPS_LAST) begin
                    core_nxt.step = 4'h0;
                    core_nxt.slot = core_r.slot + 3'h1;
                end
            end
        end
    end

    // core side registers, power-on defaults
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_r         <= '0;
            core_r.mode7   <= `LDK_MODE7_RESET;
            core_r.dset    <= `LDK_DSET_RESET;
            core_r.addr    <= `LDK_ADDR_RESET;
            core_r.pw      <= `LDK_PW_RESET;
            core_r.disp_on <= 1'b0;
        end else begin
            core_r <= core_nxt;
        end
    end

    // display ram, contents undefined until the host writes it
    always_ff @(posedge clk) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    assign segment_keysource_outputs  = core_r.seg;
    assign segment_eleven_output      = core_r.seg11;
    assign shared_segment_grid_output = core_r.shared;
    assign grid_drive_outputs         = core_r.grid;
    assign display_enabled            = core_r.disp_on;
    assign seven_grid_mode            = core_r.mode7;
    assign pulse_width_code           = core_r.pw;
    assign address_pointer            = core_r.addr;

endmodule

// ===== testbench/ldk_ctrl_sva.sv
// concurrent checks on the display and key scan controller ports
`timescale 1ns/1ps
module ldk_ctrl_sva #(
    parameter int SUB_CYCLES = 64
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       shift_clock,
    input wire logic       frame_select_strobe,
    input wire logic       shared_serial_data_pin_in,
    input wire logic       shared_serial_data_pin_out,
    input wire logic       shared_serial_data_pin_oe,
    input wire logic [2:0] key_return_inputs,
    input wire logic [9:0] segment_keysource_outputs,
    input wire logic       segment_eleven_output,
    input wire logic       shared_segment_grid_output,
    input wire logic [5:0] grid_drive_outputs,
    input wire logic       display_enabled,
    input wire logic       seven_grid_mode,
    input wire logic [2:0] pulse_width_code,
    input wire logic [3:0] address_pointer
);
    // status ports live on the timing clock, so all checks sample there
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    dout_low_a: assert property (
        shared_serial_data_pin_out == 1'h0)
        else $error("data pin output not low");
    strobe_quiet_a: assert property (
        frame_select_strobe |-> !shared_serial_data_pin_oe)
        else $error("data pin pulled while strobe high");
    reset_defaults_a: assert property (
        $rose(rst_b) |-> seven_grid_mode && !display_enabled
            && pulse_width_code == 3'h0 && address_pointer == 4'h0)
        else $error("wrong state after reset release");
    mode_off_a: assert property (
        $changed(seven_grid_mode) |-> !display_enabled)
        else $error("display left on across mode change");
    dark_outputs_a: assert property (
        !display_enabled && !$past(display_enabled) |-> grid_drive_outputs == 6'h00
            && !shared_segment_grid_output && !segment_eleven_output)
        else $error("drive active while display off");
    seven_grid_a: assert property (
        seven_grid_mode && $past(seven_grid_mode)
            |-> $onehot0({shared_segment_grid_output, grid_drive_outputs}))
        else $error("more than one grid in seven grid mode");
    six_grid_a: assert property (
        !seven_grid_mode && !$past(seven_grid_mode) |-> $onehot0(grid_drive_outputs))
        else $error("more than one grid in six grid mode");
    width_alone_a: assert property (
        $changed(pulse_width_code) |-> $stable(seven_grid_mode) && $stable(address_pointer))
        else $error("width change disturbed other state");
    pointer_alone_a: assert property (
        $changed(address_pointer) |-> $stable(pulse_width_code) && $stable(display_enabled))
        else $error("pointer change disturbed other state");

    cover property ($rose(display_enabled));
    cover property ($rose(shared_serial_data_pin_oe));
    cover property ($fell(seven_grid_mode));
    cover property (address_pointer == 4'hE);
endmodule

bind ldk_ctrl ldk_ctrl_sva #(.SUB_CYCLES(SUB_CYCLES)) u_sva (
    .clk(clk), .rst_b(rst_b), .shift_clock(shift_clock),
    .frame_select_strobe(frame_select_strobe),
    .shared_serial_data_pin_in(shared_serial_data_pin_in),
    .shared_serial_data_pin_out(shared_serial_data_pin_out),
    .shared_serial_data_pin_oe(shared_serial_data_pin_oe),
    .key_return_inputs(key_return_inputs),
    .segment_keysource_outputs(segment_keysource_outputs),
    .segment_eleven_output(segment_eleven_output),
    .shared_segment_grid_output(shared_segment_grid_output),
    .grid_drive_outputs(grid_drive_outputs), .display_enabled(display_enabled),
    .seven_grid_mode(seven_grid_mode), .pulse_width_code(pulse_width_code),
    .address_pointer(address_pointer));

// ===== testbench/ldk_host_model.sv
// host side model driving strobe, shift clock and the data pin
`timescale 1ns/1ps
module ldk_host_model (
    output logic     shift_clock,
    output logic     frame_select_strobe,
    output logic     host_data,
    output logic     host_oe,
    input wire logic pin
);
    // parked: strobe high, clock high and still, pin released
    initial begin
        shift_clock = 1'h1;
        frame_select_strobe = 1'h1;
        host_data = 1'h0;
        host_oe = 1'h0;
    end

    // odd offset keeps the link edges away from the timing clock edges
    task automatic start_frame();
        #7;
        frame_select_strobe = 1'h0;
        #100;
    endtask

    // bit changes after the fall, device takes it on the rise; n below 8 aborts mid-byte
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            shift_clock = 1'h0;
            host_oe = 1'h1;
            host_data = b[i];
            #6;
            shift_clock = 1'h1;
            #6;
        end
        #120;
    endtask

    task automatic end_frame();
        frame_select_strobe = 1'h1;
        host_oe = 1'h0;
        #200;
    endtask

    // key read: command, wait, then sample each bit after its falling edge
    task automatic read_keys(output logic [39:0] bits);
        start_frame();
        put_bits(8'h72, 8);
        host_oe = 1'h0;
        #1000;
        for (int i = 0; i < 40; i++) begin
            shift_clock = 1'h0;
            #6;
            bits[i] = pin;
            shift_clock = 1'h1;
            #6;
        end
        end_frame();
    endtask
endmodule

// ===== testbench/ldk_ctrl_tb.sv
// self-checking bench for the display and key scan controller
`timescale 1ns/1ps
module ldk_ctrl_tb;
    logic       clk;
    logic       rst_b;
    logic [2:0] keys;
    logic       sck;
    logic       stb;
    logic       hdata;
    logic       hoe;
    wire        pin;
    logic       dout;
    logic       doe;
    logic [9:0] segs;
    logic       seg11;
    logic       shared;
    logic [5:0] grids;
    logic       disp;
    logic       seven;
    logic [2:0] pw;
    logic [3:0] ptr;
    int         n_fail;
    int         checks;

    // pull-up resolves the open-drain pin when nobody pulls low
    assign pin = doe ? dout : (hoe ? hdata : 1'h1);

    ldk_ctrl #(.SUB_CYCLES(2)) uut (
        .clk(clk), .rst_b(rst_b), .shift_clock(sck), .frame_select_strobe(stb),
        .shared_serial_data_pin_in(pin), .shared_serial_data_pin_out(dout),
        .shared_serial_data_pin_oe(doe), .key_return_inputs(keys),
        .segment_keysource_outputs(segs), .segment_eleven_output(seg11),
        .shared_segment_grid_output(shared), .grid_drive_outputs(grids),
        .display_enabled(disp), .seven_grid_mode(seven), .pulse_width_code(pw),
        .address_pointer(ptr));

    ldk_host_model host (
        .shift_clock(sck), .frame_select_strobe(stb), .host_data(hdata),
        .host_oe(hoe), .pin(pin));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic status(input logic [3:0] s, input logic [3:0] d,
                          input logic [3:0] p, input logic [3:0] a);
        check("seven_grid_mode", 8'(seven), 8'(s));
        check("display_enabled", 8'(disp), 8'(d));
        check("pulse_width_code", 8'(pw), 8'(p));
        check("address_pointer", 8'(ptr), 8'(a));
    endtask

    // bytes go out low byte first; the wait covers the crossing into the core
    task automatic frame(input logic [31:0] w, input int n);
        host.start_frame();
        for (int i = 0; i < n; i++) begin
            host.put_bits(w[8*i +: 8], 8);
        end
        host.end_frame();
        repeat (10) @(negedge clk);
    endtask

    // only the low six bits of each key byte carry keys
    task automatic rd(input logic [2:0] k);
        logic [39:0] b;
        host.read_keys(b);
        for (int i = 0; i < 5; i++) begin
            check("key byte", {2'h0, b[8*i +: 6]}, {2'h0, k, k});
        end
        repeat (10) @(negedge clk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial begin
        n_fail = 0;
        checks = 0;
        rst_b = 1'h0;
        keys = 3'h5;
        repeat (2) @(negedge clk);
        rst_b = 1'h1;
        repeat (3) @(negedge clk);
        status(4'h1, 4'h0, 4'h0, 4'h0);
        $display("test reset done");
        frame(32'h0000_008D, 1);
        status(4'h1, 4'h1, 4'h5, 4'h0);
        host.start_frame();
        host.put_bits(8'h80, 4);
        host.end_frame();
        repeat (10) @(negedge clk);
        status(4'h1, 4'h1, 4'h5, 4'h0);
        frame(32'h0000_0080, 1);
        status(4'h1, 4'h0, 4'h0, 4'h0);
        $display("test control done");
        frame(32'h0000_008B, 1);
        frame(32'h0000_003C, 1);
        status(4'h0, 4'h0, 4'h3, 4'h0);
        frame(32'h0000_0088, 1);
        frame(32'h0000_003C, 1);
        status(4'h0, 4'h1, 4'h0, 4'h0);
        frame(32'h0000_0001, 1);
        status(4'h1, 4'h0, 4'h0, 4'h0);
        frame(32'h0000_008F, 1);
        $display("test mode done");
        frame(32'h0000_00CC, 1);
        status(4'h1, 4'h1, 4'h7, 4'hC);
        frame(32'h3322_1170, 4);
        status(4'h1, 4'h1, 4'h7, 4'hE);
        frame(32'h0000_00C3, 1);
        frame(32'h0066_5544, 3);
        status(4'h1, 4'h1, 4'h7, 4'h3);
        frame(32'h0000_00CF, 1);
        frame(32'h0000_AA40, 2);
        status(4'h1, 4'h1, 4'h7, 4'hF);
        // digit 6 holds bytes 11h and 22h and shows on the seventh grid
        for (int i = 0; i < 600 && shared !== 1'h1; i++) begin
            @(negedge clk);
        end
        check("grid seven", 8'(shared), 8'h01);
        check("digit low", segs[7:0], 8'h11);
        check("digit high", {5'h0, seg11, segs[9:8]}, 8'h02);
        $display("test write done");
        repeat (1500) @(negedge clk);
        rd(3'h5);
        keys = 3'h2;
        repeat (1500) @(negedge clk);
        rd(3'h2);
        $display("test read done");
        // reset in mid-run: read mode must be gone, so a data byte lands again
        rst_b = 1'h0;
        repeat (2) @(negedge clk);
        rst_b = 1'h1;
        repeat (3) @(negedge clk);
        status(4'h1, 4'h0, 4'h0, 4'h0);
        frame(32'h0000_55C0, 2);
        status(4'h1, 4'h0, 4'h0, 4'h1);
        $display("test second reset done");
        end_sim();
    end
endmodule
